// file: hw/system_reset_controller.sv
/*
 * system reset controller: merges power-on, external pin, brown-out and
 * watchdog reset sources, stretches the internal reset by a start-up
 * time-out, records reset causes and serves them over an avalon-mm slave.
 * assumes nrst_in is the power-on detector output (low while supply is
 * low), the pin and brown-out inputs are asynchronous, and the watchdog
 * expiry and fuse inputs are on clk_in or static.
 */

// Summary of operation
// (R01) io registers forced; start at reset vector
// (R02) io reset immediate, needs no clock
// (R03) delay counter stretches reset after sources
// (R04) watchdog resets only when enabled
// (R05) long pin low pulse resets without clock
// (R06) pin rising edge starts delay counter
// (R07) power-on holds reset, reasserts immediately
// (R08) enabled brown-out resets immediately, then delays
// (R09) watchdog pulse one cycle, delay follows
// (R10) watchdog flag bit 3, cleared by zero
// (R11) brown-out flag bit 2, cleared by zero
// (R12) external flag bit 1, cleared by zero
// (R13) power-on flag bit 0, software clears only
// (R14) software reads then clears flags early
// (R15) writing one keeps flag; bits 7-4 zero
// (R16) fuse-selected length; restart on reassertion
module system_reset_controller
#(
    parameter int SHORT_TIMEOUT_CYCLES = reset_ctrl_pkg::SHORT_TIMEOUT_CYCLES,
    parameter int LONG_TIMEOUT_CYCLES = reset_ctrl_pkg::LONG_TIMEOUT_CYCLES
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ext_reset_n_in,
    input wire logic brownout_detect_in,
    input wire logic brownout_enable_fuse_in,
    input wire reset_ctrl_pkg::clock_select_t clock_select_fuses_in,
    input wire logic wdt_expire_in,
    input wire logic wdt_enable_in,
    input wire logic [3:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    output logic io_reset_out,
    output logic core_reset_out,
    output logic fetch_start_out,
    output logic [15:0] fetch_addr_out,
    output logic irq_out
);
    import reset_ctrl_pkg::*;

    logic src_any_n;
    logic release_sync;
    logic ext_active;
    logic brownout_active;
    logic ext_prev_reg;
    logic brownout_prev_reg;
    logic ext_evt;
    logic brownout_evt;
    logic delay_start;
    logic delay_done;
    logic [CNT_W-1:0] delay_len;
    phase_t phase_reg;
    phase_t phase_next;
    logic [CAUSE_W-1:0] cause_reg;
    logic [CAUSE_W-1:0] cause_set;
    logic [CAUSE_W-1:0] irq_status_reg;
    logic [CAUSE_W-1:0] irq_mask_reg;
    logic [CAUSE_W-1:0] irq_evt;
    logic ack_reg;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic [31:0] read_value;

    // time-out length for a fuse setting
    function automatic logic [CNT_W-1:0] timeout_len(input clock_select_t sel);
        case (sel)
            SEL_MIN: timeout_len = CNT_W'(MIN_TIMEOUT_CYCLES);
            SEL_SHORT: timeout_len = CNT_W'(SHORT_TIMEOUT_CYCLES);
            default: timeout_len = CNT_W'(LONG_TIMEOUT_CYCLES);
        endcase
    endfunction : timeout_len

    // word value of a register, upper bits zero
    function automatic logic [31:0] widen(input logic [CAUSE_W-1:0] v);
        widen = {{(32 - CAUSE_W){1'b0}}, v};
    endfunction : widen

    // an active power-on, pin or enabled brown-out source pulls this low at once, clock or not
    assign src_any_n = nrst_in && ext_reset_n_in
        && !(brownout_enable_fuse_in && brownout_detect_in); // [R05] [R07] [R08]

    // release edge of all sources, brought onto the clock
    level_sync u_release_sync
    (
        .clk_in(clk_in),
        .nrst_in(src_any_n),
        .d_in(1'b1),
        .q_out(release_sync)
    );

    // pin level seen by the flag logic
    level_sync u_ext_sync
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .d_in(!ext_reset_n_in),
        .q_out(ext_active)
    );

    // brown-out level, counted only while the enable fuse is set
    level_sync u_brownout_sync
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .d_in(brownout_enable_fuse_in && brownout_detect_in),
        .q_out(brownout_active)
    );

    // length follows the clock-select fuses
    assign delay_len = timeout_len(clock_select_fuses_in); // [R16]
    // counter restarts while sources are held and after a watchdog pulse
    assign delay_start = (phase_reg == PH_SOURCE) || (phase_reg == PH_WATCHDOG); // [R16]

    startup_delay u_delay
    (
        .clk_in(clk_in),
        .nrst_in(release_sync),
        .start_in(delay_start),
        .length_in(delay_len),
        .done_out(delay_done)
    );

    // sequencer next state
    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_SOURCE: phase_next = PH_DELAY; // [R06] [R07]
            PH_DELAY:
            begin
                if (delay_done)
                    phase_next = PH_RUN; // [R03]
            end
            PH_RUN:
            begin
                if (wdt_expire_in && wdt_enable_in)
                    phase_next = PH_WATCHDOG; // [R04]
            end
            PH_WATCHDOG: phase_next = PH_DELAY; // [R09]
            default: phase_next = PH_SOURCE;
        endcase
    end

    // sequencer held in the source state until all sources release
    always_ff @(posedge clk_in or negedge release_sync)
    begin
        if (!release_sync)
            phase_reg <= PH_SOURCE;
        else
            phase_reg <= phase_next;
    end

    // internal reset until running; io reset also follows raw sources
    assign core_reset_out = (phase_reg != PH_RUN); // [R01] [R03]
    assign io_reset_out = !src_any_n || core_reset_out; // [R01] [R02]

    // start pulse and vector address at the release
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fetch_start_out <= 1'b0;
            fetch_addr_out <= RESET_VECTOR;
        end
        else
        begin
            fetch_start_out <= (phase_reg == PH_DELAY) && delay_done; // [R01]
            fetch_addr_out <= RESET_VECTOR;
        end
    end

    // rising edges of the synchronised levels
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ext_prev_reg <= 1'b0;
            brownout_prev_reg <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= ext_active;
            brownout_prev_reg <= brownout_active;
        end
    end
    assign ext_evt = ext_active && !ext_prev_reg;
    assign brownout_evt = brownout_active && !brownout_prev_reg;

    // causes raised this cycle
    always_comb
    begin
        cause_set = '0;
        cause_set[WATCHDOG_FLAG_BIT] = (phase_reg == PH_WATCHDOG); // [R10]
        cause_set[BROWNOUT_FLAG_BIT] = brownout_active; // [R11]
        cause_set[EXTERNAL_FLAG_BIT] = ext_active; // [R12]
    end

    // bus handshake: one wait cycle, then the answer
    assign bus_req = read_in || write_in;
    assign waitrequest_out = bus_req && !ack_reg;
    assign wr_take = write_in && ack_reg;
    assign rd_take = read_in && ack_reg;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ack_reg <= 1'b0;
        else
            ack_reg <= bus_req && !ack_reg;
    end

    // cause flags survive all but power-on; a set beats a clear
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cause_reg <= CAUSE_RESET; // [R13]
        else if (wr_take && address_in == CAUSE_OFS && byteenable_in[0])
            cause_reg <= (cause_reg & writedata_in[CAUSE_W-1:0]) | cause_set; // [R15] [R14]
        else
            cause_reg <= cause_reg | cause_set; // [R10] [R11] [R12]
    end

    // interrupt events: release plus the pin, brown-out and watchdog causes
    always_comb
    begin
        irq_evt = '0;
        irq_evt[RELEASE_EVT_BIT] = (phase_reg == PH_DELAY) && delay_done;
        irq_evt[EXTERNAL_FLAG_BIT] = ext_evt;
        irq_evt[BROWNOUT_FLAG_BIT] = brownout_evt;
        irq_evt[WATCHDOG_FLAG_BIT] = (phase_reg == PH_WATCHDOG);
    end

    // sticky status, cleared by a read, set wins over clear
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            irq_status_reg <= '0;
        else if (rd_take && address_in == IRQ_STATUS_OFS)
            // clear only the bits that the read returned, so none is lost
            irq_status_reg <= (irq_status_reg & ~readdata_out[CAUSE_W-1:0]) | irq_evt;
        else
            irq_status_reg <= irq_status_reg | irq_evt;
    end

    // interrupt mask
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            irq_mask_reg <= MASK_RESET;
        else if (wr_take && address_in == IRQ_MASK_OFS && byteenable_in[0])
            irq_mask_reg <= writedata_in[CAUSE_W-1:0];
    end

    assign irq_out = |(irq_status_reg & irq_mask_reg);

    // read mux; unmapped offsets read zero
    always_comb
    begin
        case (address_in)
            CAUSE_OFS: read_value = widen(cause_reg); // [R15]
            IRQ_STATUS_OFS: read_value = widen(irq_status_reg);
            IRQ_MASK_OFS: read_value = widen(irq_mask_reg);
            STATE_OFS: read_value = {28'h0000000, clock_select_fuses_in, phase_reg};
            default: read_value = 32'h00000000;
        endcase
    end

    // read data captured in the wait cycle, stands in the answer cycle
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            readdata_out <= 32'h00000000;
        else if (read_in && !ack_reg)
            readdata_out <= read_value;
    end

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    chk_io_reset_now: assert property (ext_active |-> io_reset_out) // [R02]
        else $error("io reset not active during external reset");
    chk_wdt_enabled: assert property (
        phase_reg == PH_WATCHDOG |-> $past(wdt_expire_in && wdt_enable_in)) // [R04]
        else $error("watchdog reset without enabled expiry");
    chk_wdt_pulse_len: assert property (
        phase_reg == PH_WATCHDOG |=> phase_reg == PH_DELAY && core_reset_out) // [R09]
        else $error("watchdog pulse not followed by delay");
    chk_release_done: assert property ($fell(core_reset_out) |-> $past(delay_done)) // [R03]
        else $error("reset released before time-out");
    chk_wdt_flag: assert property (
        phase_reg == PH_WATCHDOG |=> cause_reg[WATCHDOG_FLAG_BIT]) // [R10]
        else $error("watchdog flag not set");
    chk_brownout_flag: assert property (brownout_evt |=> cause_reg[BROWNOUT_FLAG_BIT]) // [R11]
        else $error("brown-out flag not set");
    chk_ext_flag: assert property (ext_evt |=> cause_reg[EXTERNAL_FLAG_BIT]) // [R12]
        else $error("external flag not set");
    chk_one_keeps: assert property (
        wr_take && address_in == CAUSE_OFS && writedata_in[POWER_ON_FLAG_BIT]
        && cause_reg[POWER_ON_FLAG_BIT] |=> cause_reg[POWER_ON_FLAG_BIT]) // [R15] [R13]
        else $error("writing one changed power-on flag");
    chk_upper_zero: assert property (
        rd_take && address_in == CAUSE_OFS |-> readdata_out[31:CAUSE_W] == '0) // [R15]
        else $error("reserved cause bits not zero");
    chk_fetch_vector: assert property ($fell(core_reset_out) |-> fetch_start_out) // [R01]
        else $error("no fetch start at release");

    // sources and the delay hold the core, power-on sets its flag
    chk_pin_hold: assert property (!ext_reset_n_in |-> core_reset_out && phase_reg == PH_SOURCE) // [R05] [R16]
        else $error("pin low but sequencer not held");
    chk_brownout_hold: assert property (brownout_enable_fuse_in && brownout_detect_in // [R08]
        |-> io_reset_out && phase_reg == PH_SOURCE)
        else $error("enabled brown-out did not hold reset");
    chk_delay_hold: assert property (phase_reg == PH_DELAY && !delay_done |=> core_reset_out) // [R03]
        else $error("core released before the delay ended");
    chk_wdt_gate: assert property ( // [R04]
        phase_reg == PH_RUN && !wdt_enable_in |=> phase_reg != PH_WATCHDOG)
        else $error("watchdog reset while disabled");
    chk_power_on_flag: assert property ($rose(nrst_in) |-> cause_reg == CAUSE_RESET) // [R13]
        else $error("power-on flag not set after power-on");

    // main scenarios reached
    cov_wdt_reset: cover property (phase_reg == PH_WATCHDOG ##[1:100] !core_reset_out);
    cov_restart: cover property (phase_reg == PH_DELAY ##1 phase_reg == PH_SOURCE);
    cov_ext_reset: cover property (ext_evt);
    cov_brownout_reset: cover property (brownout_evt);
    cov_irq_raise: cover property ($rose(irq_out));
endmodule : system_reset_controller

// file: hw/reset_ctrl_pkg.sv
/*
 * constants shared by the reset controller: timing counts, register
 * offsets, field positions, reset values and the sequencer states.
 * assumes a single 25 MHz system clock.
 */
package reset_ctrl_pkg;
    // system clock rate
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    // start-up time-out choices, in microseconds, and in cycles
    localparam int SHORT_TIMEOUT_US = 4100;
    localparam int LONG_TIMEOUT_US = 65000;
    localparam int SHORT_TIMEOUT_CYCLES = SHORT_TIMEOUT_US * CLK_MHZ;
    localparam int LONG_TIMEOUT_CYCLES = LONG_TIMEOUT_US * CLK_MHZ;
    localparam int MIN_TIMEOUT_CYCLES = 6;
    localparam int CNT_W = 21;
    // register byte offsets
    localparam logic [3:0] CAUSE_OFS = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h4;
    localparam logic [3:0] IRQ_MASK_OFS = 4'h8;
    localparam logic [3:0] STATE_OFS = 4'hC;
    // reset-cause register fields
    localparam int CAUSE_W = 4;
    localparam int POWER_ON_FLAG_BIT = 0;
    localparam int EXTERNAL_FLAG_BIT = 1;
    localparam int BROWNOUT_FLAG_BIT = 2;
    localparam int WATCHDOG_FLAG_BIT = 3;
    localparam int RELEASE_EVT_BIT = 0;
    localparam logic [3:0] CAUSE_RESET = 4'h1;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // address where execution starts after release
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // clock-select fuse encodings of the time-out
    typedef enum logic [1:0] {
        SEL_MIN = 2'h0,
        SEL_SHORT = 2'h1,
        SEL_LONG = 2'h2,
        SEL_LONG_ALT = 2'h3
    } clock_select_t;
    // reset sequencer states
    typedef enum logic [1:0] {
        PH_SOURCE = 2'h0,
        PH_DELAY = 2'h1,
        PH_RUN = 2'h2,
        PH_WATCHDOG = 2'h3
    } phase_t;
endpackage : reset_ctrl_pkg

// file: hw/level_sync.sv
/*
 * two-flip-flop synchroniser for one level.
 * assumes an asynchronous active-low reset that clears both stages.
 */
module level_sync
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_reg <= 1'b0;
            q_out <= 1'b0;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule : level_sync

// file: hw/startup_delay.sv
/*
 * start-up delay counter: counts up to a selected length after a start.
 * assumes start is held or pulsed by the sequencer on the same clock.
 */
module startup_delay
    import reset_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic [reset_ctrl_pkg::CNT_W-1:0] length_in,
    output logic done_out
);
    logic [CNT_W-1:0] count_reg;

    // restart on every start, else count until the length is reached
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            count_reg <= '0;
        else if (start_in)
            count_reg <= '0;
        else if (count_reg < length_in)
            count_reg <= count_reg + 1'b1;
    end

    // finished once the count covers the length
    assign done_out = !start_in && (count_reg >= length_in);
endmodule : startup_delay

// file: tb/system_reset_controller_bench.sv
/*
 * self-checking bench for the system reset controller: drives the reset
 * sources and fuses, and reads the cause, irq and state registers over avalon-mm.
 * assumes short time-outs of 20 and 40 cycles and a 25 MHz clock.
 */
module system_reset_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_ctrl_pkg::*;
    localparam int SHORT_L = 20;
    localparam int LONG_L = 40;
    logic clk_in, nrst_in, ext_reset_n_in, brownout_detect_in, brownout_enable_fuse_in;
    clock_select_t clock_select_fuses_in;
    logic wdt_expire_in, wdt_enable_in, read_in, write_in;
    logic [3:0] address_in, byteenable_in;
    logic [31:0] writedata_in, readdata_out, junk;
    logic waitrequest_out, io_reset_out, core_reset_out, fetch_start_out, irq_out;
    logic [15:0] fetch_addr_out;
    int failures = 0;
    int n_checks = 0;

    // device under test with shortened time-outs
    system_reset_controller #(.SHORT_TIMEOUT_CYCLES(SHORT_L), .LONG_TIMEOUT_CYCLES(LONG_L)) u_dut
    (
        .clk_in(clk_in), .nrst_in(nrst_in), .ext_reset_n_in(ext_reset_n_in),
        .brownout_detect_in(brownout_detect_in),
        .brownout_enable_fuse_in(brownout_enable_fuse_in),
        .clock_select_fuses_in(clock_select_fuses_in), .wdt_expire_in(wdt_expire_in),
        .wdt_enable_in(wdt_enable_in), .address_in(address_in), .read_in(read_in),
        .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .io_reset_out(io_reset_out), .core_reset_out(core_reset_out),
        .fetch_start_out(fetch_start_out), .fetch_addr_out(fetch_addr_out), .irq_out(irq_out)
    );

    // 40 ns clock
    always #20 clk_in = ~clk_in;

    // compare and count
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // verdict and end of run
    task wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // one avalon transfer, held until the rising edge that samples waitrequest low
    task bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
             output logic [31:0] rdata);
        int i;
        rdata = 32'h00000000;
        @(posedge clk_in);
        address_in <= addr;
        writedata_in <= wdata;
        read_in <= !wr;
        write_in <= wr;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk_in);
            if (waitrequest_out === 1'b0)
                break;
        end
        if (i == 50)
        begin
            failures++;
            wrap_up();
        end
        // taken at this edge: data as sampled, then release
        rdata = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask : bus

    task rd(input logic [3:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, d);
        check(d, exp);
    endtask : rd

    task wr(input logic [3:0] addr, input logic [31:0] val);
        bus(1'b1, addr, val, junk);
    endtask : wr

    // measures the stretch of core reset and checks the fetch start
    task wait_release(input int len);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (core_reset_out !== 1'b0 && n < len + 20)
        begin
            @(negedge clk_in);
            n++;
            if (fetch_start_out === 1'b1)
                seen = 1'b1;
        end
        @(negedge clk_in);
        if (fetch_start_out === 1'b1)
            seen = 1'b1;
        check(n >= len, 1'b1);
        check(n <= len + 8, 1'b1);
        check(seen, 1'b1);
        check(fetch_addr_out, RESET_VECTOR);
    endtask : wait_release

    // pulls the pin low for four cycles
    task pin_pulse;
        @(posedge clk_in);
        ext_reset_n_in <= 1'b0;
        #1 check(io_reset_out, 1'b1);
        repeat (4) @(posedge clk_in);
        ext_reset_n_in <= 1'b1;
    endtask : pin_pulse

    // hang guard
    initial
    begin
        #(40 * 100000);
        failures++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        clk_in = 1'b0;
        nrst_in = 1'b0;
        ext_reset_n_in = 1'b1;
        brownout_detect_in = 1'b0;
        brownout_enable_fuse_in = 1'b0;
        clock_select_fuses_in = SEL_MIN;
        wdt_expire_in = 1'b0;
        wdt_enable_in = 1'b0;
        address_in = 4'h0;
        read_in = 1'b0;
        write_in = 1'b0;
        writedata_in = 32'h0;
        byteenable_in = 4'hF;
        repeat (4) @(posedge clk_in);
        check({io_reset_out, core_reset_out, irq_out}, 3'h6);
        nrst_in <= 1'b1;
        wait_release(MIN_TIMEOUT_CYCLES);
        rd(CAUSE_OFS, 32'h1);
        wr(CAUSE_OFS, 32'hFF);
        rd(CAUSE_OFS, 32'h1);
        wr(CAUSE_OFS, 32'h0);
        rd(CAUSE_OFS, 32'h0);
        rd(4'h2, 32'h0);
        rd(STATE_OFS, 32'h2);
        $display("test power-on and cause register done");
        // pin reset, reasserted in mid-delay
        clock_select_fuses_in <= SEL_SHORT;
        pin_pulse();
        repeat (10) @(posedge clk_in);
        check(core_reset_out, 1'b1);
        pin_pulse();
        wait_release(SHORT_L);
        rd(CAUSE_OFS, 32'h2);
        wr(CAUSE_OFS, 32'h0);
        $display("test external reset done");
        // brown-out ignored, then enabled
        @(posedge clk_in);
        brownout_detect_in <= 1'b1;
        #1 check(io_reset_out, 1'b0);
        repeat (4) @(posedge clk_in);
        brownout_detect_in <= 1'b0;
        check(core_reset_out, 1'b0);
        rd(CAUSE_OFS, 32'h0);
        clock_select_fuses_in <= SEL_LONG;
        brownout_enable_fuse_in <= 1'b1;
        @(posedge clk_in);
        brownout_detect_in <= 1'b1;
        #1 check(io_reset_out, 1'b1);
        repeat (4) @(posedge clk_in);
        brownout_detect_in <= 1'b0;
        wait_release(LONG_L);
        rd(CAUSE_OFS, 32'h4);
        wr(CAUSE_OFS, 32'h0);
        $display("test brown-out done");
        // watchdog disabled, then enabled, with interrupt
        clock_select_fuses_in <= SEL_MIN;
        rd(IRQ_STATUS_OFS, 32'h7);
        @(posedge clk_in);
        wdt_expire_in <= 1'b1;
        @(posedge clk_in);
        wdt_expire_in <= 1'b0;
        @(negedge clk_in);
        check(core_reset_out, 1'b0);
        rd(CAUSE_OFS, 32'h0);
        check(irq_out, 1'b0);
        @(posedge clk_in);
        wdt_enable_in <= 1'b1;
        wdt_expire_in <= 1'b1;
        @(posedge clk_in);
        wdt_expire_in <= 1'b0;
        @(negedge clk_in);
        check(core_reset_out, 1'b1);
        wait_release(MIN_TIMEOUT_CYCLES);
        rd(CAUSE_OFS, 32'h8);
        check(irq_out, 1'b0);
        wr(IRQ_MASK_OFS, 32'h8);
        @(negedge clk_in);
        check(irq_out, 1'b1);
        rd(IRQ_STATUS_OFS, 32'h9);
        @(negedge clk_in);
        check(irq_out, 1'b0);
        // a write without byte lane 0 leaves the mask alone
        byteenable_in <= 4'hE;
        wr(IRQ_MASK_OFS, 32'h0);
        byteenable_in <= 4'hF;
        rd(IRQ_MASK_OFS, 32'h8);
        $display("test watchdog and interrupt done");
        // power-on in mid-run clears the other flags
        pin_pulse();
        wait_release(MIN_TIMEOUT_CYCLES);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        wait_release(MIN_TIMEOUT_CYCLES);
        rd(CAUSE_OFS, 32'h1);
        rd(IRQ_MASK_OFS, {28'h0, MASK_RESET});
        $display("test second power-on done");
        wrap_up();
    end
endmodule : system_reset_controller_bench
